// ---- hdl/cbd_params.svh ----
// constants for the commissioning button decoder: offsets, fields, resets, times
// assumes a 125 MHz system clock; times are turned into counts here
`ifndef CBD_PARAMS_SVH
`define CBD_PARAMS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CBD_CLK_HZ        125000000
`define CBD_MS_CYCLES     (`CBD_CLK_HZ / 1000)
`define CBD_WINDOW_S      2
`define CBD_WINDOW_MS     (`CBD_WINDOW_S * 1000)
`define CBD_AWAKE_S       30
`define CBD_AWAKE_MS      (`CBD_AWAKE_S * 1000)
`define CBD_BLINK_S       1
`define CBD_BLINK_MS      (`CBD_BLINK_S * 1000)
`define CBD_BLINK_HALF_MS 50
`define CBD_DEBOUNCE_MS   10

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define CBD_REG_CTRL   4'h0
`define CBD_REG_CMD    4'h4
`define CBD_REG_STATUS 4'h8

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CBD_CTRL_BTN_EN  0
`define CBD_CTRL_SM_LO   4
`define CBD_CTRL_SM_HI   7
`define CBD_CTRL_NOM_EN  8
`define CBD_CTRL_API     9
`define CBD_CTRL_LED_EN  10
`define CBD_CMD_CNT_HI   2
`define CBD_CMD_RESTORE  8
`define CBD_ST_CNT_HI    2
`define CBD_ST_WINDOW    3
`define CBD_ST_LED       4
`define CBD_ST_BLINK     5
`define CBD_ST_AWAKE     6
`define CBD_ST_QUEUED    7

// ----------------------------------------------------------------
// reset and default values
// ----------------------------------------------------------------
`define CBD_BTN_EN_RST 1'b1
`define CBD_SM_RST     4'h0
`define CBD_NOM_EN_RST 1'b0
`define CBD_API_RST    1'b1
`define CBD_LED_EN_RST 1'b1

// ----------------------------------------------------------------
// encodings
// ----------------------------------------------------------------
`define CBD_SM_NONE    4'h0
`define CBD_SM_SYNC_A  4'h7
`define CBD_SM_SYNC_B  4'h8
`define CBD_FRAME_TYPE 8'h95

`endif

// ---- hdl/cbd_pkg.sv ----
// types shared by the commissioning button decoder
// assumes nothing beyond a SystemVerilog compiler
package cbd_pkg;

	// ----------------------------------------------------------------
	// enumerations
	// ----------------------------------------------------------------
	typedef enum logic {
		CBD_IDLE   = 1'b0,
		CBD_WINDOW = 1'b1
	} cbd_fsm_t;

	typedef enum logic [1:0] {
		CBD_SLP_NONE  = 2'b00,
		CBD_SLP_ASYNC = 2'b01,
		CBD_SLP_SYNC  = 2'b10
	} cbd_sleep_t;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic         valid;
		logic [63:0]  addr;
		logic [159:0] label;
	} cbd_rx_t;

	typedef struct packed {
		logic         valid;
		logic [7:0]   ftype;
		logic [63:0]  addr;
		logic [159:0] label;
	} cbd_frame_t;

	typedef struct packed {
		cbd_fsm_t   fsm;
		logic [23:0] tick_cnt;
		logic [15:0] deb_cnt;
		logic        btn_db;
		logic [15:0] win_cnt;
		logic [2:0]  press_cnt;
		logic        awake;
		logic [15:0] awake_cnt;
		logic        queued;
		logic        blink;
		logic [15:0] blink_cnt;
		logic        led;
		logic [15:0] led_cnt;
		logic        id_tx;
		logic        nominate;
		logic        restore;
		cbd_frame_t  frame;
		logic        btn_en;
		logic [3:0]  sm;
		logic        nom_en;
		logic        api;
		logic        led_en;
		logic        waitreq;
		logic [31:0] rdata;
	} cbd_state_t;

endpackage

// ---- hdl/cbd_top.sv ----
// commissioning button decoder: press counting, actions, receive indication
// assumes button_n and the network inputs are synchronous to clk,
// and an Avalon-MM master that holds each request until waitrequest is low
//
// Behaviour
// - button works only while enable bit is 1
// - presses count together within two seconds
// - one press, no sleep: send broadcast now
// - one press, async sleep: wake 30s, send
// - one press, sync sleep: wake, queue broadcast
// - received broadcast blinks LED for one second
// - api mode: emit frame type 0x95
// - two presses, sync, nomination: become coordinator
// - four presses: restore all defaults
// - software command simulates given press count
// - frame carries sender address and label
//
// The address map and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/100ps
`include "cbd_params.svh"

module cbd_top #(
	parameter logic [23:0] MS_CYCLES   = 24'(`CBD_MS_CYCLES),
	parameter logic [15:0] WINDOW_MS   = 16'(`CBD_WINDOW_MS),
	parameter logic [15:0] AWAKE_MS    = 16'(`CBD_AWAKE_MS),
	parameter logic [15:0] BLINK_MS    = 16'(`CBD_BLINK_MS),
	parameter logic [15:0] HALF_MS     = 16'(`CBD_BLINK_HALF_MS),
	parameter logic [15:0] DEBOUNCE_MS = 16'(`CBD_DEBOUNCE_MS)
) (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic [3:0]         avs_address,
	input  wire logic               avs_read,
	input  wire logic               avs_write,
	input  wire logic [31:0]        avs_writedata,
	output      logic [31:0]        avs_readdata,
	output      logic               avs_waitrequest,
	input  wire logic               button_n,
	input  wire logic               net_wake,
	input  wire logic               net_sleep,
	input  wire cbd_pkg::cbd_rx_t    rx,
	output      logic               id_bcast_tx,
	output      logic               nominate_coord,
	output      logic               param_restore,
	output      logic               stay_awake,
	output      logic               led_blink,
	output      cbd_pkg::cbd_frame_t frame
);

	// ----------------------------------------------------------------
	// state and decode
	// ----------------------------------------------------------------
	cbd_pkg::cbd_state_t s;
	cbd_pkg::cbd_state_t next_s;
	cbd_pkg::cbd_sleep_t cls;
	logic                tick;
	logic                raw;
	logic                press;
	logic                wr_go;
	logic                act_v;
	logic [2:0]          act_cnt;
	logic [31:0]         rd_val;

	function automatic cbd_pkg::cbd_sleep_t sleep_class(input logic [3:0] sm);
		if (sm == `CBD_SM_NONE) begin
			return cbd_pkg::CBD_SLP_NONE;
		end else if (sm == `CBD_SM_SYNC_A || sm == `CBD_SM_SYNC_B) begin
			return cbd_pkg::CBD_SLP_SYNC;
		end else begin
			return cbd_pkg::CBD_SLP_ASYNC;
		end
	endfunction

	assign raw   = ~button_n;
	assign tick  = (s.tick_cnt == MS_CYCLES - 24'h1);
	assign cls   = sleep_class(s.sm);
	assign wr_go = avs_write & ~s.waitreq;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s  = s;
		press   = 1'b0;
		act_v   = 1'b0;
		act_cnt = 3'h0;
		rd_val  = 32'h0;
		next_s.id_tx       = 1'b0;
		next_s.nominate    = 1'b0;
		next_s.restore     = 1'b0;
		next_s.frame.valid = 1'b0;
		// millisecond enable keeps every long counter at 16 bits
		next_s.tick_cnt = tick ? 24'h0 : s.tick_cnt + 24'h1;

		// level must stay changed for the whole debounce time
		if (raw == s.btn_db) begin
			next_s.deb_cnt = 16'h0;
		end else if (tick) begin
			if (s.deb_cnt == DEBOUNCE_MS - 16'h1) begin
				next_s.btn_db  = raw;
				next_s.deb_cnt = 16'h0;
			end else begin
				next_s.deb_cnt = s.deb_cnt + 16'h1;
			end
		end
		press = next_s.btn_db & ~s.btn_db & s.btn_en;

		case (s.fsm)
			cbd_pkg::CBD_IDLE: begin
				if (press) begin
					next_s.fsm       = cbd_pkg::CBD_WINDOW;
					next_s.win_cnt   = 16'h0;
					next_s.press_cnt = 3'h1;
				end
			end
			cbd_pkg::CBD_WINDOW: begin
				if (press && s.press_cnt != 3'h7) begin
					next_s.press_cnt = s.press_cnt + 3'h1;
				end
				if (tick) begin
					if (s.win_cnt == WINDOW_MS - 16'h1) begin
						act_v            = 1'b1;
						act_cnt          = next_s.press_cnt;
						next_s.fsm       = cbd_pkg::CBD_IDLE;
						next_s.press_cnt = 3'h0;
						next_s.win_cnt   = 16'h0;
					end else begin
						next_s.win_cnt = s.win_cnt + 16'h1;
					end
				end
			end
			default: begin
				next_s.fsm = cbd_pkg::CBD_IDLE;
			end
		endcase

		// software press count wins over a window expiring in the same cycle
		if (wr_go && avs_address == `CBD_REG_CMD &&
			avs_writedata[`CBD_CMD_CNT_HI:0] != 3'h0) begin
			act_v   = 1'b1;
			act_cnt = avs_writedata[`CBD_CMD_CNT_HI:0];
		end

		if (s.awake) begin
			if (tick) begin
				if (s.awake_cnt == AWAKE_MS - 16'h1) begin
					next_s.awake = 1'b0;
				end else begin
					next_s.awake_cnt = s.awake_cnt + 16'h1;
				end
			end
			if (cls == cbd_pkg::CBD_SLP_SYNC && net_sleep) begin
				next_s.awake = 1'b0;
			end
		end

		if (s.queued && net_wake) begin
			next_s.id_tx  = 1'b1;
			next_s.queued = 1'b0;
		end

		if (act_v) begin
			case (act_cnt)
				3'h1: begin
					if (cls != cbd_pkg::CBD_SLP_SYNC) begin
						next_s.id_tx = 1'b1;
					end else begin
						next_s.queued = 1'b1;
					end
					if (cls != cbd_pkg::CBD_SLP_NONE) begin
						next_s.awake     = 1'b1;
						next_s.awake_cnt = 16'h0;
					end
				end
				3'h2: begin
					if (cls == cbd_pkg::CBD_SLP_SYNC && s.nom_en) begin
						next_s.nominate = 1'b1;
					end
				end
				3'h4: begin
					next_s.restore = 1'b1;
				end
				default: begin
					next_s.restore = 1'b0;
				end
			endcase
		end

		if (s.blink && tick) begin
			if (s.blink_cnt == BLINK_MS - 16'h1) begin
				next_s.blink = 1'b0;
				next_s.led   = 1'b0;
			end else begin
				next_s.blink_cnt = s.blink_cnt + 16'h1;
				if (s.led_cnt == HALF_MS - 16'h1) begin
					next_s.led     = ~s.led;
					next_s.led_cnt = 16'h0;
				end else begin
					next_s.led_cnt = s.led_cnt + 16'h1;
				end
			end
		end
		// a new broadcast restarts the full second
		if (rx.valid && s.led_en) begin
			next_s.blink     = 1'b1;
			next_s.blink_cnt = 16'h0;
			next_s.led       = 1'b1;
			next_s.led_cnt   = 16'h0;
		end
		if (rx.valid && s.api) begin
			next_s.frame.valid = 1'b1;
			next_s.frame.ftype = `CBD_FRAME_TYPE;
			next_s.frame.addr  = rx.addr;
			next_s.frame.label = rx.label;
		end

		// one wait cycle, then one ready cycle; ready never holds two cycles
		case (avs_address)
			`CBD_REG_CTRL: begin
				rd_val[`CBD_CTRL_BTN_EN]                  = s.btn_en;
				rd_val[`CBD_CTRL_SM_HI:`CBD_CTRL_SM_LO]   = s.sm;
				rd_val[`CBD_CTRL_NOM_EN]                  = s.nom_en;
				rd_val[`CBD_CTRL_API]                     = s.api;
				rd_val[`CBD_CTRL_LED_EN]                  = s.led_en;
			end
			`CBD_REG_STATUS: begin
				rd_val[`CBD_ST_CNT_HI:0] = s.press_cnt;
				rd_val[`CBD_ST_WINDOW]   = (s.fsm == cbd_pkg::CBD_WINDOW);
				rd_val[`CBD_ST_LED]      = s.led;
				rd_val[`CBD_ST_BLINK]    = s.blink;
				rd_val[`CBD_ST_AWAKE]    = s.awake;
				rd_val[`CBD_ST_QUEUED]   = s.queued;
			end
			default: begin
				rd_val = 32'h0;
			end
		endcase
		next_s.waitreq = 1'b1;
		if ((avs_read || avs_write) && s.waitreq) begin
			next_s.waitreq = 1'b0;
			next_s.rdata   = rd_val;
		end
		if (wr_go && avs_address == `CBD_REG_CTRL) begin
			next_s.btn_en = avs_writedata[`CBD_CTRL_BTN_EN];
			next_s.sm     = avs_writedata[`CBD_CTRL_SM_HI:`CBD_CTRL_SM_LO];
			next_s.nom_en = avs_writedata[`CBD_CTRL_NOM_EN];
			next_s.api    = avs_writedata[`CBD_CTRL_API];
			next_s.led_en = avs_writedata[`CBD_CTRL_LED_EN];
		end
		if (wr_go && avs_address == `CBD_REG_CMD && avs_writedata[`CBD_CMD_RESTORE]) begin
			next_s.restore = 1'b1;
		end
		// restore overrides a control write landing in the same cycle
		if (next_s.restore) begin
			next_s.btn_en = `CBD_BTN_EN_RST;
			next_s.sm     = `CBD_SM_RST;
			next_s.nom_en = `CBD_NOM_EN_RST;
			next_s.api    = `CBD_API_RST;
			next_s.led_en = `CBD_LED_EN_RST;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s         <= '0;
			s.waitreq <= 1'b1;
			s.btn_en  <= `CBD_BTN_EN_RST;
			s.sm      <= `CBD_SM_RST;
			s.nom_en  <= `CBD_NOM_EN_RST;
			s.api     <= `CBD_API_RST;
			s.led_en  <= `CBD_LED_EN_RST;
		end else begin
			s <= next_s;
		end
	end

	assign avs_readdata    = s.rdata;
	assign avs_waitrequest = s.waitreq;
	assign id_bcast_tx     = s.id_tx;
	assign nominate_coord  = s.nominate;
	assign param_restore   = s.restore;
	assign stay_awake      = s.awake;
	assign led_blink       = s.led;
	assign frame           = s.frame;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	restore_enable_a: assert property (
		@(posedge clk) disable iff (!rst_n) s.restore |-> s.btn_en)
		else $error("restore left button disabled");
	window_end_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(s.fsm == cbd_pkg::CBD_WINDOW && tick && s.win_cnt == WINDOW_MS - 16'h1)
		|=> s.fsm == cbd_pkg::CBD_IDLE && s.press_cnt == 3'h0)
		else $error("window did not close on time");
	one_none_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(act_v && act_cnt == 3'h1 && cls == cbd_pkg::CBD_SLP_NONE)
		|=> s.id_tx && !s.awake)
		else $error("single press without sleep did not send");
	one_async_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(act_v && act_cnt == 3'h1 && cls == cbd_pkg::CBD_SLP_ASYNC)
		|=> s.id_tx && s.awake && s.awake_cnt == 16'h0)
		else $error("async single press wrong");
	queued_send_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(s.queued && net_wake) |=> s.id_tx)
		else $error("queued broadcast not sent at wake");
	one_sync_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(act_v && act_cnt == 3'h1 && cls == cbd_pkg::CBD_SLP_SYNC && !(s.queued && net_wake))
		|=> s.queued && s.awake && !s.id_tx)
		else $error("sync single press wrong");
	blink_stop_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(s.blink && tick && s.blink_cnt == BLINK_MS - 16'h1 && !rx.valid)
		|=> !s.blink && !s.led)
		else $error("blink did not end after one second");
	frame_out_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(rx.valid && s.api) |=> s.frame.valid && s.frame.ftype == `CBD_FRAME_TYPE
		&& s.frame.addr == $past(rx.addr))
		else $error("indication frame missing or wrong");
	two_press_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(act_v && act_cnt == 3'h2)
		|=> s.nominate == ($past(cls) == cbd_pkg::CBD_SLP_SYNC && $past(s.nom_en)))
		else $error("two press nomination wrong");
	four_press_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(act_v && act_cnt == 3'h4) |=> s.restore ##1 !s.restore)
		else $error("four presses did not restore once");
	sim_cmd_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(wr_go && avs_address == `CBD_REG_CMD && avs_writedata[`CBD_CMD_CNT_HI:0] == 3'h2)
		|-> act_v && act_cnt == 3'h2)
		else $error("press command not acted on");
	debounce_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		press |-> tick && s.deb_cnt == DEBOUNCE_MS - 16'h1 && raw)
		else $error("press taken before debounce time");
	odd_count_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(act_v && act_cnt == 3'h3 && !wr_go && !(s.queued && net_wake))
		|=> !s.id_tx && !s.nominate && !s.restore)
		else $error("unsupported count caused an action");
	bus_answer_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		((avs_read || avs_write) && s.waitreq) |=> !s.waitreq ##1 s.waitreq)
		else $error("bus answer not one cycle");

endmodule

// ---- test/cbd_button_model.sv ----
// pushbutton model: a switch to ground with a pull-up on the pin
// assumes the bench calls its tasks right after a rising clock edge
`timescale 1ns/100ps

module cbd_button_model #(
	parameter int PRESS_CYCLES = 14
) (
	input  wire logic clk,
	output      logic button_n
);
	// pull-up: the released pin reads high
	initial button_n = 1'b1;

	// each half outlasts the decoder's debounce time
	task automatic press(input int n);
		repeat (n) begin
			button_n <= 1'b0;
			repeat (PRESS_CYCLES) @(posedge clk);
			button_n <= 1'b1;
			repeat (PRESS_CYCLES) @(posedge clk);
		end
	endtask

	// holds the pin low for the given cycles, then releases it for PRESS_CYCLES; a hold past debounce counts as one press
	task automatic hold(input int cycles);
		button_n <= 1'b0;
		repeat (cycles) @(posedge clk);
		button_n <= 1'b1;
		repeat (PRESS_CYCLES) @(posedge clk);
	endtask
endmodule

// ---- test/cbd_top_tb.sv ----
// self-checking bench for the commissioning button decoder
// assumes a shortened time base: 1 clock a tick, 160-tick window
`timescale 1ns/100ps
`include "cbd_params.svh"

module cbd_top_tb;
	logic                clk;
	logic                rst_n;
	logic [3:0]          avs_address;
	logic                avs_read;
	logic                avs_write;
	logic [31:0]         avs_writedata;
	logic [31:0]         avs_readdata;
	logic                avs_waitrequest;
	wire                 button_n;
	logic                net_wake;
	logic                net_sleep;
	cbd_pkg::cbd_rx_t    rx;
	logic                id_bcast_tx;
	logic                nominate_coord;
	logic                param_restore;
	logic                stay_awake;
	logic                led_blink;
	cbd_pkg::cbd_frame_t frame;
	cbd_pkg::cbd_frame_t last_frame;
	cbd_pkg::cbd_frame_t exp_frame;
	logic [31:0]         rd;
	int                  n_errors;
	int                  samples_checked;
	int                  cycles;
	int                  n_id;
	int                  n_nom;
	int                  n_rst;
	int                  n_frm;
	int                  n_led;

	// blink, blink half-period and debounce keep their full-length defaults
	cbd_top #(.MS_CYCLES(24'h1), .WINDOW_MS(16'ha0), .AWAKE_MS(16'hc8)) DUT (
		.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .button_n(button_n), .net_wake(net_wake),
		.net_sleep(net_sleep), .rx(rx), .id_bcast_tx(id_bcast_tx),
		.nominate_coord(nominate_coord), .param_restore(param_restore),
		.stay_awake(stay_awake), .led_blink(led_blink), .frame(frame));

	cbd_button_model BTN (.clk(clk), .button_n(button_n));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// monitor and hang guard
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		cycles++;
		n_id += int'(id_bcast_tx === 1'b1);
		n_nom += int'(nominate_coord === 1'b1);
		n_rst += int'(param_restore === 1'b1);
		n_frm += int'(frame.valid === 1'b1);
		n_led += int'(led_blink === 1'b1);
		if (frame.valid === 1'b1) last_frame = frame;
		if (cycles == 10000) begin
			n_errors++;
			summarize();
		end
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic summarize();
		if (n_errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [255:0] e, input logic [255:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %0h seen %0h", what, e, g);
		end
	endtask

	// request held until waitrequest is sampled low
	// only the cycle guard ends a wait that never completes
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic clr();
		n_id = 0;
		n_nom = 0;
		n_rst = 0;
		n_frm = 0;
		n_led = 0;
	endtask

	task automatic chk3(input int ei, input int en, input int er);
		chk("broadcast", ei, n_id);
		chk("nominate", en, n_nom);
		chk("restore", er, n_rst);
	endtask

	// window of 160 clocks plus margin before judging
	task automatic act(input int n, input int ei, input int en, input int er);
		clr();
		BTN.press(n);
		cyc(200);
		chk3(ei, en, er);
	endtask

	task automatic sw(input logic [31:0] c, input int ei, input int en, input int er);
		clr();
		bus(1'b1, `CBD_REG_CMD, c);
		cyc(10);
		chk3(ei, en, er);
	endtask

	task automatic recv();
		clr();
		@(posedge clk);
		rx <= '{valid: 1'b1, addr: 64'h0123456789abcdef, label: 160'h6c6162656c5f6f6e65};
		@(posedge clk);
		rx.valid <= 1'b0;
		cyc(100);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		net_wake = 1'b0;
		net_sleep = 1'b0;
		rx = '0;
		n_errors = 0;
		samples_checked = 0;
		cycles = 0;
		clr();
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		bus(1'b0, `CBD_REG_CTRL, 32'h0);
		chk("ctrl reset", 32'h601, rd);
		bus(1'b1, 4'hc, 32'hffffffff);
		bus(1'b0, 4'hc, 32'h0);
		chk("unmapped", 32'h0, rd);
		clr();
		BTN.press(1);
		cyc(100);
		chk("early broadcast", 0, n_id);
		cyc(100);
		chk3(1, 0, 0);
		chk("awake none", 1'b0, stay_awake);
		clr();
		BTN.hold(4);
		cyc(200);
		chk3(0, 0, 0);
		act(2, 0, 0, 0);
		act(3, 0, 0, 0);
		bus(1'b1, `CBD_REG_CTRL, 32'h611);
		act(1, 1, 0, 0);
		chk("awake async", 1'b1, stay_awake);
		cyc(200);
		chk("awake ends", 1'b0, stay_awake);
		bus(1'b1, `CBD_REG_CTRL, 32'h771);
		clr();
		BTN.hold(40);
		cyc(200);
		chk3(0, 0, 0);
		chk("awake sync", 1'b1, stay_awake);
		bus(1'b0, `CBD_REG_STATUS, 32'h0);
		chk("status sync", 32'hc0, rd);
		@(posedge clk);
		net_sleep <= 1'b1;
		@(posedge clk);
		net_sleep <= 1'b0;
		cyc(3);
		chk("sleep ends", 1'b0, stay_awake);
		act(2, 0, 1, 0);
		clr();
		@(posedge clk);
		net_wake <= 1'b1;
		@(posedge clk);
		net_wake <= 1'b0;
		cyc(3);
		chk("queued sent", 1, n_id);
		bus(1'b1, `CBD_REG_CTRL, 32'h600);
		act(1, 0, 0, 0);
		bus(1'b1, `CBD_REG_CTRL, 32'h771);
		act(4, 0, 0, 1);
		bus(1'b0, `CBD_REG_CTRL, 32'h0);
		chk("ctrl restored", 32'h601, rd);
		sw(32'h1, 1, 0, 0);
		bus(1'b1, `CBD_REG_CTRL, 32'h781);
		sw(32'h2, 0, 1, 0);
		sw(32'h4, 0, 0, 1);
		sw(32'h100, 0, 0, 1);
		exp_frame = '{valid: 1'b1, ftype: 8'h95, addr: 64'h0123456789abcdef,
			label: 160'h6c6162656c5f6f6e65};
		recv();
		// let the full-length blink run out before judging it
		cyc(1000);
		chk("frame count", 1, n_frm);
		chk("frame", exp_frame, last_frame);
		chk("blink span", 1'b1, n_led >= 490 && n_led <= 510);
		chk("blink off", 1'b0, led_blink);
		bus(1'b1, `CBD_REG_CTRL, 32'h1);
		recv();
		chk("no frame", 0, n_frm);
		chk("no blink", 0, n_led);
		summarize();
	end
endmodule
